// ---- modbus_serial_port_slave.sv ----
// modbus slave serial port: uart, rtu/ascii framing, rts/cts handshake
`timescale 1ns/10ps
module modbus_serial_port_slave
  import modbus_serial_pkg::*;
#(
  parameter bit FIXED_RS485 = 1'b0,
  parameter int unsigned CYC_PER_MS = CYCLES_PER_MS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire config_s cfg,
  input wire logic rxd,
  output logic txd,
  output logic txEnable,
  input wire logic cts,
  output logic rts,
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic rxValid,
  input wire logic rxReady,
  output logic [7:0] rxData,
  output status_s status
);
  // ************************************************************
  // mode decode
  // ************************************************************
  logic isRs485, hsOn, flowCtl, modemCtl, ascii;
  logic [3:0] dataBits;
  logic [16:0] bitLen;
  assign isRs485 = FIXED_RS485 | cfg.rs485Sel;
  assign hsOn = !isRs485 && cfg.handshakeSel;
  assign flowCtl = hsOn && (cfg.hsDelaySteps == 7'h00);
  assign modemCtl = hsOn && (cfg.hsDelaySteps != 7'h00);
  assign ascii = cfg.asciiSel;
  assign dataBits = ascii ? 4'h7 : 4'h8;
  assign bitLen = bitCycles(cfg.baud);

  // ************************************************************
  // receive fifo
  // ************************************************************
  logic fifoInValid, fifoInReady;
  logic [7:0] fifoInData;
  logic [5:0] fifoLevel;
  modbus_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clock(clock), .rst_b(rst_b),
    .inValid(fifoInValid), .inReady(fifoInReady), .inData(fifoInData),
    .outValid(rxValid), .outReady(rxReady), .outData(rxData), .level(fifoLevel)
  );

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_WAIT = 2'h1, TX_SHIFT = 2'h2, TX_TAIL = 2'h3} tx_e;
  typedef struct packed {
    logic [1:0] rxSync;
    logic rxActive;
    logic [16:0] rxCnt;
    logic [3:0] rxBit;
    logic [9:0] rxShift;
    logic [31:0] idleCnt;
    logic inFrame;
    logic frameBad;
    logic [15:0] crc;
    logic [7:0] lrc;
    logic [3:0] hexHi;
    logic nibOdd;
    logic sawCr;
    logic addrMatch;
    logic [7:0] byteIdx;
    logic frameOk;
    logic frameErr;
    tx_e txState;
    logic [16:0] txCnt;
    logic [3:0] txBit;
    logic [11:0] txShift;
    logic [31:0] hsCnt;
    logic [15:0] txCrc;
    logic [1:0] tailIdx;
    logic rtsOut;
    logic discarded;
    logic txLine;
  } state_s;
  state_s r, next_r;

  logic rxDone, parityOk;
  logic [7:0] rxByte;
  logic [31:0] eofCycles, ifdCycles, hsLimit;
  logic [31:0] frameIdle;
  logic [11:0] txFrame;
  logic [7:0] txByteSel;
  logic ctsOk;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  function automatic logic [3:0] hexVal(input logic [6:0] ch);
    return (ch >= 7'h41) ? 4'(ch - 7'h37) : 4'(ch - 7'h30);
  endfunction

  // serial frame: start, data, parity, stop(s), lsb first
  function automatic logic [11:0] buildFrame(input logic [7:0] d, input logic a, input logic [1:0] p);
    logic [7:0] m;
    logic par;
    m = a ? {1'b0, d[6:0]} : d;
    par = ^m ^ (p == PAR_ODD);
    if (p == PAR_NONE) begin
      buildFrame = a ? {4'hF, m[6:0], 1'b0} : {3'h7, m, 1'b0};
    end else begin
      buildFrame = a ? {3'h7, par, m[6:0], 1'b0} : {2'h3, par, m, 1'b0};
    end
  endfunction

  always_comb begin
    logic [3:0] frameBits;
    frameBits = 4'(1 + dataBits + ((cfg.parity != PAR_NONE) ? 1 : 0) + (cfg.twoStop ? 2 : 1));
    // 3.5 chars: bit length * bits per char * 7 / 2
    eofCycles = (32'(bitLen) * 32'(frameBits) * EOF_HALF_CHARS) >> 1;
    ifdCycles = cfg.ifdDefault ? 32'(bitLen) * 32'(frameBits) * 32'(IFD_DEFAULT_MS)
                               : 32'(cfg.ifdMs) * 32'(CYC_PER_MS);
    frameIdle = eofCycles + ifdCycles;
    hsLimit = 32'(cfg.hsDelaySteps) * 32'(HS_STEP_MS) * 32'(CYC_PER_MS);
    rxByte = ascii ? {1'b0, r.rxShift[6:0]} : r.rxShift[7:0];
    parityOk = (cfg.parity == PAR_NONE) ||
               ((^(r.rxShift[8:0] & (ascii ? 9'h0FF : 9'h1FF))) == (cfg.parity == PAR_ODD));
    rxDone = 1'b0;
    ctsOk = !hsOn || cts;
    txByteSel = txData;
    txFrame = buildFrame(txByteSel, ascii, cfg.parity);
    fifoInValid = 1'b0;
    fifoInData = rxByte;
    next_r = r;
    next_r.frameOk = 1'b0;
    next_r.frameErr = 1'b0;
    next_r.discarded = 1'b0;
    next_r.rxSync = {r.rxSync[0], rxd};

    // receiver
    if (!r.rxActive) begin
      if (!r.rxSync[1]) begin
        next_r.rxActive = 1'b1;
        next_r.rxCnt = bitLen >> 1;
        next_r.rxBit = 4'h0;
      end
    end else if (r.rxCnt != 17'h0) begin
      next_r.rxCnt = r.rxCnt - 17'h1;
    end else begin
      next_r.rxCnt = bitLen - 17'h1;
      next_r.rxBit = r.rxBit + 4'h1;
      if (r.rxBit == dataBits + ((cfg.parity != PAR_NONE) ? 4'h2 : 4'h1)) begin
        // end mid-stop: a low parity or data bit must not look like a start
        next_r.rxActive = 1'b0;
        rxDone = 1'b1;
      end else if (r.rxBit != 4'h0) begin
        next_r.rxShift = {r.rxSync[1], r.rxShift[9:1]};
      end
    end
    if (rxDone) begin
      // align captured bits down to bit 0
      next_r.rxShift = r.rxShift >> (4'hA - dataBits - ((cfg.parity != PAR_NONE) ? 4'h1 : 4'h0));
    end
    next_r.idleCnt = (r.rxActive || !r.rxSync[1]) ? 32'h0 : ((r.idleCnt == 32'hFFFFFFFF) ? r.idleCnt : r.idleCnt + 32'h1);

    // framing, registered byte one cycle after rxDone
    if (r.byteIdx[7] == 1'b0 && r.rxActive == 1'b0 && r.rxCnt == 17'h0 && r.rxBit != 4'h0 && 1'b0) begin
      next_r.byteIdx = r.byteIdx;
    end
    if (r.rxBit == 4'hF) begin
      next_r.rxBit = 4'h0;
    end
    if (!r.rxActive && r.rxBit != 4'h0) begin
      next_r.rxBit = 4'h0;
      if (!parityOk) begin
        next_r.frameBad = 1'b1;
      end
      if (!ascii) begin
        if (!r.inFrame) begin
          next_r.inFrame = 1'b1;
          next_r.frameBad = !parityOk;
          next_r.crc = crcStep(CRC_PRESET, rxByte);
          next_r.addrMatch = (rxByte == cfg.slaveAddr) || (rxByte == 8'h00) || (cfg.slaveAddr == ADDR_P2P);
          next_r.byteIdx = 8'h1;
        end else begin
          next_r.crc = crcStep(r.crc, rxByte);
        end
        fifoInValid = r.addrMatch || !r.inFrame;
      end else if (rxByte[6:0] == CHR_COLON) begin
        next_r.inFrame = 1'b1;
        next_r.frameBad = !parityOk;
        next_r.lrc = 8'h00;
        next_r.nibOdd = 1'b0;
        next_r.sawCr = 1'b0;
        fifoInValid = 1'b1;
      end else if (r.inFrame) begin
        fifoInValid = 1'b1;
        if (rxByte[6:0] == CHR_CR) begin
          next_r.sawCr = 1'b1;
        end else if (r.sawCr && rxByte[6:0] == CHR_LF) begin
          next_r.inFrame = 1'b0;
          // lrc byte summed in makes the total zero
          if (r.frameBad || r.lrc != 8'h00 || r.nibOdd) begin
            next_r.frameErr = 1'b1;
          end else begin
            next_r.frameOk = 1'b1;
          end
        end else begin
          next_r.sawCr = 1'b0;
          next_r.nibOdd = !r.nibOdd;
          if (r.nibOdd) begin
            next_r.lrc = r.lrc + {r.hexHi, hexVal(rxByte[6:0])};
          end else begin
            next_r.hexHi = hexVal(rxByte[6:0]);
          end
        end
      end
    end
    // rtu end of frame on silence; residue zero means crc matched
    if (!ascii && r.inFrame && r.idleCnt >= frameIdle) begin
      next_r.inFrame = 1'b0;
      if (r.frameBad || r.crc != 16'h0000) begin
        next_r.frameErr = 1'b1;
      end else if (r.addrMatch) begin
        next_r.frameOk = 1'b1;
      end
    end

    // flow control rts from fifo headroom
    if (flowCtl) begin
      next_r.rtsOut = (fifoLevel < 6'(RTS_LOW_WATER));
    end else if (!modemCtl) begin
      next_r.rtsOut = 1'b0;
    end

    // transmitter
    txReady = 1'b0;
    unique case (r.txState)
      TX_IDLE: begin
        next_r.txLine = 1'b1;
        if (txValid) begin
          if (modemCtl) begin
            next_r.rtsOut = 1'b1;
            next_r.hsCnt = 32'h0;
            next_r.txState = TX_WAIT;
          end else if (ctsOk) begin
            txReady = 1'b1;
            next_r.txShift = txFrame;
            next_r.txCnt = bitLen - 17'h1;
            next_r.txBit = 4'h0;
            next_r.txCrc = crcStep(r.txCrc, txData);
            next_r.tailIdx = txLast ? 2'h1 : 2'h0;
            next_r.txState = TX_SHIFT;
          end
        end
      end
      TX_WAIT: begin
        next_r.hsCnt = r.hsCnt + 32'h1;
        if (cts) begin
          next_r.txState = TX_IDLE;
          next_r.hsCnt = 32'h0;
          txReady = 1'b1;
          next_r.txShift = txFrame;
          next_r.txCnt = bitLen - 17'h1;
          next_r.txBit = 4'h0;
          next_r.txCrc = crcStep(r.txCrc, txData);
          next_r.tailIdx = txLast ? 2'h1 : 2'h0;
          next_r.txState = TX_SHIFT;
        end else if (r.hsCnt >= hsLimit) begin
          txReady = 1'b1;
          next_r.discarded = 1'b1;
          next_r.rtsOut = 1'b0;
          next_r.txState = TX_IDLE;
        end
      end
      TX_SHIFT, TX_TAIL: begin
        next_r.txLine = r.txShift[0];
        if (r.txCnt != 17'h0) begin
          next_r.txCnt = r.txCnt - 17'h1;
        end else begin
          next_r.txCnt = bitLen - 17'h1;
          next_r.txShift = {1'b1, r.txShift[11:1]};
          next_r.txBit = r.txBit + 4'h1;
          if (r.txBit == frameBits - 4'h1) begin
            next_r.txBit = 4'h0;
            if (r.tailIdx == 2'h0) begin
              next_r.txState = TX_IDLE;
            end else begin
              // rtu appends crc low then high; ascii appends cr lf
              unique case (r.tailIdx)
                2'h1: txByteSel = ascii ? {1'b0, CHR_CR} : r.txCrc[7:0];
                default: txByteSel = ascii ? {1'b0, CHR_LF} : r.txCrc[15:8];
              endcase
              next_r.txShift = buildFrame(txByteSel, ascii, cfg.parity);
              next_r.tailIdx = (r.tailIdx == 2'h2 || r.txState == TX_SHIFT && 1'b0) ? 2'h0 : r.tailIdx + 2'h1;
              if (r.tailIdx == 2'h2) begin
                next_r.txCrc = CRC_PRESET;
                next_r.tailIdx = 2'h3;
              end
              next_r.txState = TX_TAIL;
            end
            if (r.tailIdx == 2'h3) begin
              next_r.tailIdx = 2'h0;
              next_r.txState = TX_IDLE;
              if (modemCtl) begin
                next_r.rtsOut = 1'b0;
              end
            end
          end
        end
      end
      default: next_r.txState = TX_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r <= '0;
      r.rxSync <= 2'h3;
      r.crc <= CRC_PRESET;
      r.txCrc <= CRC_PRESET;
      r.txLine <= 1'b1;
      r.txState <= TX_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign txd = r.txLine;
  assign txEnable = (r.txState == TX_SHIFT) || (r.txState == TX_TAIL);
  assign rts = hsOn && r.rtsOut;
  assign status = '{frameOk: r.frameOk, frameErr: r.frameErr, reqDiscarded: r.discarded,
                    rtsOut: rts, txBusy: r.txState != TX_IDLE};

  // ************************************************************
  // checks
  // ************************************************************
  a_rs485_no_rts: assert property (@(posedge clock) disable iff (!rst_b) isRs485 |-> !rts)
    else $error("rts driven with rs485");
  a_flow_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (flowCtl && fifoLevel >= 6'(RTS_LOW_WATER)) |=> !r.rtsOut)
    else $error("rts not dropped near full");
  a_cts_gate: assert property (@(posedge clock) disable iff (!rst_b)
    (r.txState == TX_IDLE && hsOn && !cts) |-> !txReady)
    else $error("sent without cts");
  a_modem_rts: assert property (@(posedge clock) disable iff (!rst_b)
    (r.txState == TX_WAIT) |-> r.rtsOut)
    else $error("waiting without rts");
  a_discard_drop: assert property (@(posedge clock) disable iff (!rst_b)
    r.discarded |-> (r.txState == TX_IDLE && !r.rtsOut))
    else $error("discard left rts high");
  a_err_ok_excl: assert property (@(posedge clock) disable iff (!rst_b) !(r.frameOk && r.frameErr))
    else $error("ok and error together");
  a_line_idle: assert property (@(posedge clock) disable iff (!rst_b)
    (r.txState == TX_IDLE && $past(r.txState) == TX_IDLE) |-> txd)
    else $error("line not idle high");
  a_hs_off_mode: assert property (@(posedge clock) disable iff (!rst_b)
    !hsOn |-> (r.txState != TX_WAIT))
    else $error("wait state outside handshake mode");
  c_frame_ok: cover property (@(posedge clock) disable iff (!rst_b) r.frameOk);
  c_frame_err: cover property (@(posedge clock) disable iff (!rst_b) r.frameErr);
  c_discard: cover property (@(posedge clock) disable iff (!rst_b) r.discarded);
endmodule // modbus_serial_port_slave

// ---- modbus_serial_pkg.sv ----
// shared constants and carriers for the modbus serial slave port
package modbus_serial_pkg;
  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLOCK_HZ = 20000000;
  localparam int unsigned MS_PER_SEC = 1000;
  localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / MS_PER_SEC;
  localparam int unsigned HS_STEP_MS = 100;
  localparam int unsigned IFD_DEFAULT_MS = 2;
  localparam int unsigned IFD_MIN_MS = 2;
  localparam int unsigned IFD_MAX_MS = 10000;
  localparam int unsigned HS_MAX_STEPS = 100;
  // end-of-frame silence in half character times: 3.5 chars = 7 halves
  localparam int unsigned EOF_HALF_CHARS = 7;
  localparam int unsigned OVERSAMPLE = 16;
  // ************************************************************
  // config encodings
  // ************************************************************
  typedef enum logic [2:0] {
    BAUD_300 = 3'h0, BAUD_600 = 3'h1, BAUD_1200 = 3'h2, BAUD_2400 = 3'h3,
    BAUD_4800 = 3'h4, BAUD_9600 = 3'h5, BAUD_19200 = 3'h6
  } baud_e;
  typedef enum logic [1:0] {PAR_EVEN = 2'h0, PAR_ODD = 2'h1, PAR_NONE = 2'h2} parity_e;
  localparam logic [7:0] ADDR_DEFAULT = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] ADDR_P2P = 8'hF8;
  localparam logic [6:0] CHR_COLON = 7'h3A;
  localparam logic [6:0] CHR_CR = 7'h0D;
  localparam logic [6:0] CHR_LF = 7'h0A;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned RTS_LOW_WATER = 24;

  typedef struct packed {
    logic rs485Sel;
    logic handshakeSel;
    logic [6:0] hsDelaySteps;
    logic [2:0] baud;
    logic ifdDefault;
    logic [13:0] ifdMs;
    logic asciiSel;
    logic twoStop;
    logic [1:0] parity;
    logic [7:0] slaveAddr;
  } config_s;

  typedef struct packed {
    logic frameOk;
    logic frameErr;
    logic reqDiscarded;
    logic rtsOut;
    logic txBusy;
  } status_s;

  // bit period in clock cycles, per selected rate
  function automatic logic [16:0] bitCycles(input logic [2:0] b);
    unique case (b)
      3'h0: bitCycles = 17'(CLOCK_HZ / 300);
      3'h1: bitCycles = 17'(CLOCK_HZ / 600);
      3'h2: bitCycles = 17'(CLOCK_HZ / 1200);
      3'h3: bitCycles = 17'(CLOCK_HZ / 2400);
      3'h4: bitCycles = 17'(CLOCK_HZ / 4800);
      3'h6: bitCycles = 17'(CLOCK_HZ / 19200);
      default: bitCycles = 17'(CLOCK_HZ / 9600);
    endcase
  endfunction
endpackage

// ---- modbus_fifo.sv ----
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/10ps
module modbus_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr;
  logic [AW:0] count;
  logic push, pop;
  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr];
  assign level = count;
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // modbus_fifo

// ---- modbus_master_model.sv ----
// serial master model facing the slave port: drives its receive line, decodes its transmit line
`timescale 1ns/10ps
module modbus_master_model
  import modbus_serial_pkg::*;
#(
  parameter int unsigned BAUD_RATE = 19200
) (
  input wire logic clock,
  input wire logic txLine,
  output logic rxLine,
  output logic ctsLine
);
  // ************************************************************
  // line drivers and decoder
  // ************************************************************
  localparam int BIT_LEN = CLOCK_HZ / BAUD_RATE;
  initial begin
    rxLine = 1'b1;
    ctsLine = 1'b0;
  end
  // lag lets the medium grant late, as a slow modem would
  task automatic set_cts(input logic v, input int lag);
    repeat (lag + 1) @(negedge clock);
    ctsLine = v;
  endtask
  task automatic drive_bit(input logic b);
    @(negedge clock);
    rxLine = b;
    repeat (BIT_LEN - 1) @(negedge clock);
  endtask
  // par: 0 even, 1 odd, 2 none; lsb first, line back to idle mark after stops
  task automatic send_char(input logic [7:0] d, input logic [1:0] par, input int nStop);
    drive_bit(1'b0);
    for (int i = 0; i < 8; i++) drive_bit(d[i]);
    if (par != 2'h2) drive_bit(^d ^ par[0]);
    repeat (nStop) drive_bit(1'b1);
  endtask
  // samples mid-bit on the falling edge, clear of the slave's register updates
  task automatic recv_char(output logic [7:0] d, output logic p, output logic [1:0] s);
    int n;
    n = 0;
    while (txLine !== 1'b0 && n < 20 * BIT_LEN) begin
      @(negedge clock);
      n++;
    end
    repeat (BIT_LEN / 2) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_LEN) @(negedge clock);
      d[i] = txLine;
    end
    repeat (BIT_LEN) @(negedge clock);
    p = txLine;
    for (int i = 0; i < 2; i++) begin
      repeat (BIT_LEN) @(negedge clock);
      s[i] = txLine;
    end
  endtask
endmodule // modbus_master_model

// ---- testbench.sv ----
// self-checking bench for the modbus serial slave port
`timescale 1ns/10ps
module testbench
  import modbus_serial_pkg::*;
;
  // ************************************************************
  // harness
  // ************************************************************
  logic clock, rst_b, rxd, txd, txEnable, cts, rts, txValid, txReady, txLast, rxValid, rxReady;
  logic [7:0] txData, rxData;
  config_s cfg;
  status_s status;
  int n_fail = 0;
  int checks = 0;
  modbus_serial_port_slave #(.FIXED_RS485(1'b0), .CYC_PER_MS(20)) modbus_serial_port_slave_inst (
    .clock(clock), .rst_b(rst_b), .cfg(cfg), .rxd(rxd), .txd(txd), .txEnable(txEnable), .cts(cts),
    .rts(rts), .txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData), .status(status));
  modbus_master_model modbus_master_model_inst (.clock(clock), .txLine(txd), .rxLine(rxd), .ctsLine(cts));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic finish_test();
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_bit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic config_s base_cfg();
    config_s c;
    c = '0;
    c.baud = BAUD_19200;
    c.ifdMs = 14'h0002;
    c.parity = PAR_EVEN;
    c.slaveAddr = ADDR_DEFAULT;
    return c;
  endfunction
  function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    return r;
  endfunction
  task automatic start_up(input config_s c);
    @(negedge clock);
    rst_b = 1'b0;
    cfg = c;
    txValid = 1'b0;
    rxReady = 1'b0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
  endtask
  // stops just after the falling edge before the accepting edge; low records any start bit meanwhile
  task automatic wait_accept(input int limit, output int n, output logic low);
    n = 0;
    low = 1'b0;
    #1;
    while (n < limit && txReady !== 1'b1) begin
      @(negedge clock);
      #1;
      n++;
      if (txd === 1'b0) low = 1'b1;
    end
  endtask
  task automatic release_tx();
    @(negedge clock);
    txValid = 1'b0;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset();
    start_up(base_cfg());
    check_byte("idle outputs", 8'h08, {4'h0, txd, txEnable, rts, rxValid});
    check_byte("status", 8'h00, {3'h0, status});
  endtask
  task automatic test_tx_char();
    config_s c;
    logic [7:0] d;
    logic p, low;
    logic [1:0] s;
    int n;
    c = base_cfg();
    c.twoStop = 1'b1;
    start_up(c);
    txData = 8'hA5;
    txValid = 1'b1;
    fork
      modbus_master_model_inst.recv_char(d, p, s);
      begin
        wait_accept(10, n, low);
        check_bit("plain accept", 1'b1, n < 10);
        release_tx();
        repeat (100) @(negedge clock);
        check_bit("txEnable", 1'b1, txEnable);
      end
    join
    check_byte("tx data", 8'hA5, d);
    check_bit("tx parity", 1'b0, p);
    check_byte("tx stops", 8'h03, {6'h00, s});
  endtask
  task automatic test_flow();
    config_s c;
    logic low;
    int n;
    c = base_cfg();
    c.handshakeSel = 1'b1;
    modbus_master_model_inst.set_cts(1'b0, 0);
    start_up(c);
    txData = 8'h3C;
    txValid = 1'b1;
    wait_accept(50, n, low);
    check_bit("held without cts", 1'b1, n == 50 && txReady !== 1'b1);
    check_bit("rts empty buffer", 1'b1, rts);
    modbus_master_model_inst.set_cts(1'b1, 3);
    wait_accept(10, n, low);
    check_bit("flow accept", 1'b1, n < 10);
    release_tx();
  endtask
  task automatic test_rs485();
    config_s c;
    logic low;
    int n;
    c = base_cfg();
    c.rs485Sel = 1'b1;
    c.handshakeSel = 1'b1;
    c.hsDelaySteps = 7'h01;
    modbus_master_model_inst.set_cts(1'b0, 0);
    start_up(c);
    txValid = 1'b1;
    wait_accept(10, n, low);
    check_bit("rs485 ignores cts", 1'b1, n < 10);
    check_bit("rs485 rts", 1'b0, rts);
    release_tx();
  endtask
  task automatic test_modem();
    config_s c;
    logic low;
    int n;
    c = base_cfg();
    c.handshakeSel = 1'b1;
    c.hsDelaySteps = 7'h01;
    start_up(c);
    txValid = 1'b1;
    repeat (5) @(negedge clock);
    check_bit("modem rts", 1'b1, rts);
    wait_accept(3000, n, low);
    check_bit("discard delay", 1'b1, n > 1900 && n < 2100);
    check_bit("no start bit", 1'b0, low);
    release_tx();
    check_bit("discard pulse", 1'b1, status.reqDiscarded);
    check_bit("rts after discard", 1'b0, rts);
  endtask
  task automatic test_rx_frame();
    config_s c;
    logic [15:0] crc;
    logic err;
    int n;
    c = base_cfg();
    c.parity = PAR_ODD;
    modbus_master_model_inst.set_cts(1'b1, 0);
    start_up(c);
    // shortest frame keeps the run inside the cycle budget
    crc = crc_add(16'hFFFF, 8'h01);
    modbus_master_model_inst.send_char(8'h01, 2'h1, 1);
    modbus_master_model_inst.send_char(crc[7:0], 2'h1, 1);
    modbus_master_model_inst.send_char(crc[15:8], 2'h1, 1);
    n = 0;
    err = 1'b0;
    while (n < 60000 && status.frameOk !== 1'b1) begin
      @(negedge clock);
      n++;
      if (status.frameErr === 1'b1) err = 1'b1;
    end
    check_bit("frame ok", 1'b1, status.frameOk);
    check_bit("silence span", 1'b1, n > 34000 && n < 50000);
    check_bit("no frame error", 1'b0, err);
    rxReady = 1'b1;
    check_bit("rx valid", 1'b1, rxValid);
    check_byte("rx address", 8'h01, rxData);
    @(negedge clock);
    rxReady = 1'b0;
  endtask
  initial begin
    rst_b = 1'b0;
    cfg = base_cfg();
    txValid = 1'b0;
    txData = 8'h00;
    txLast = 1'b0;
    rxReady = 1'b0;
    test_reset();
    test_tx_char();
    test_flow();
    test_rs485();
    test_modem();
    test_rx_frame();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    finish_test();
  end
endmodule // testbench
